/* hw/llc_pkg.sv */
// Purpose: Shared constants and types for the limit latch controller.
// Assumes: APB with byte addresses; 32-bit data, one word per register.
// Notes: Process values, setpoint and alarm limits are signed 16-bit.
`default_nettype none
package llc_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] SETPOINT_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] INT_STATUS_OFS = 8'h0C;
    localparam logic [7:0] INT_MASK_OFS = 8'h10;
    localparam logic [7:0] DI_ASSIGN_OFS = 8'h14;
    localparam logic [7:0] ALM_CMD_OFS = 8'h18;
    localparam logic [7:0] ALM_BASE = 8'h20;
    localparam logic [7:0] ALM_STRIDE = 8'h10;
    localparam logic [7:0] ALM_CFG_OFS = 8'h00;
    localparam logic [7:0] ALM_LEVEL_OFS = 8'h04;
    localparam logic [7:0] ALM_DELAY_OFS = 8'h08;
    // Field positions
    localparam int CTRL_LOW_BIT = 0;
    localparam int CTRL_SRC_BIT = 1;
    localparam int INT_TRIP = 0;
    localparam int INT_ACCEPT = 1;
    localparam int INT_REFUSE = 2;
    localparam int INT_ALM_LSB = 3;
    localparam int ALM_CMD_REL_BIT = 0;
    localparam int ALM_N = 3;
    localparam int DI_N = 3;
    // Reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [5:0] MASK_RST = 6'h00;
    localparam logic [11:0] DI_RST = 12'h000;
    // Timing: alarm delay and rate sampling tick
    localparam int CLK_NS = 4;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    // Alarm kinds
    typedef enum logic [3:0] {
        ALM_NONE, ALM_PV_HI, ALM_PV_LO, ALM_DEV_HI, ALM_DEV_LO,
        ALM_DEV_OUT, ALM_DEV_IN, ALM_RATE, ALM_DIAG, ALM_FAIL
    } llc_alm_kind_t;
    // Contact input functions
    typedef enum logic [3:0] {
        DI_NONE, DI_LATCH_REL, DI_PV_RED, DI_BACKLIGHT,
        DI_MSG1, DI_MSG2, DI_MSG3, DI_MSG4
    } llc_di_func_t;
    // One alarm setting
    typedef struct packed {
        logic [15:0] off_dly;
        logic [15:0] on_dly;
        logic [7:0] hyst;
        logic [15:0] limit;
        logic latch;
        logic standby;
        logic [3:0] kind;
    } llc_alm_cfg_t;
    // Live values that every alarm watches
    typedef struct packed {
        logic [15:0] pv;
        logic [15:0] sp;
        logic [15:0] rate;
        logic diag;
        logic fail;
    } llc_meas_t;
    // APB request and answer
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } llc_apb_req_t;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } llc_apb_rsp_t;
endpackage
`default_nettype wire

/* hw/llc_alarm.sv */
// Purpose: One configurable alarm with stand-by, latch, hysteresis, delays.
// Assumes: tick is a one-cycle pulse; delays count ticks.
// Notes: Instantiated once per alarm by the limit controller.
`timescale 1ns/1ps
`default_nettype none
module llc_alarm (
    // Clock, reset, enable, timebase
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic tick,
    // Setting and live values
    input wire llc_pkg::llc_alm_cfg_t cfg,
    input wire llc_pkg::llc_meas_t meas,
    input wire logic release_req,
    // Result level and its rising event
    output logic alarm,
    output logic fire
);
    import llc_pkg::*;

    // All state of one alarm
    typedef struct packed {
        logic raw;
        logic dly;
        logic [15:0] cnt;
        logic armed;
        logic latched;
        logic out;
        logic fire;
    } llc_alm_st_t;

    llc_alm_st_t st;
    llc_alm_st_t next_st;
    logic signed [17:0] pv_x;   // Widened to keep differences exact
    logic signed [17:0] dev;
    logic signed [17:0] dev_abs;
    logic signed [17:0] rate_abs;
    logic signed [17:0] lim;
    logic signed [17:0] hys;
    logic raw_now;              // Condition after hysteresis
    logic [15:0] wait_len;

    // Condition, delay filter, stand-by and latch
    always_comb begin
        next_st = st;
        pv_x = {{2{meas.pv[15]}}, meas.pv};
        dev = pv_x - {{2{meas.sp[15]}}, meas.sp};
        dev_abs = dev[17] ? -dev : dev;
        rate_abs = {{2{meas.rate[15]}}, meas.rate};
        rate_abs = rate_abs[17] ? -rate_abs : rate_abs;
        lim = {{2{cfg.limit[15]}}, cfg.limit};
        hys = {10'h000, cfg.hyst};
        wait_len = 16'h0000;
        // Once on, the alarm holds until the value backs off by hys
        // R10 alarm kinds
        unique case (llc_alm_kind_t'(cfg.kind))
            ALM_NONE: raw_now = 1'b0;
            ALM_PV_HI: raw_now = st.raw ? pv_x > lim - hys : pv_x > lim;
            ALM_PV_LO: raw_now = st.raw ? pv_x < lim + hys : pv_x < lim;
            ALM_DEV_HI: raw_now = st.raw ? dev > lim - hys : dev > lim;
            ALM_DEV_LO: raw_now = st.raw ? dev < lim + hys : dev < lim;
            ALM_DEV_OUT: begin
                raw_now = st.raw ? dev_abs > lim - hys : dev_abs > lim;
            end
            ALM_DEV_IN: begin
                raw_now = st.raw ? dev_abs <= lim + hys : dev_abs <= lim;
            end
            ALM_RATE: begin
                raw_now = st.raw ? rate_abs > lim - hys : rate_abs > lim;
            end
            ALM_DIAG: raw_now = meas.diag;
            ALM_FAIL: raw_now = meas.fail;
            // Unused codes never alarm
            default: raw_now = 1'b0;
        endcase
        if (ce) begin
            next_st.raw = raw_now;
            wait_len = raw_now ? cfg.on_dly : cfg.off_dly;
            // R9 on/off delay
            if (raw_now == st.dly) begin
                next_st.cnt = 16'h0000;
            end else if (st.cnt >= wait_len) begin
                next_st.dly = raw_now;
                next_st.cnt = 16'h0000;
            end else if (tick) begin
                next_st.cnt = st.cnt + 16'h0001;
            end
            // R9 stand-by until first normal
            if (!cfg.standby || !next_st.dly) begin
                next_st.armed = 1'b0;
            end
            // R9 forced-reset latch
            if (release_req) begin
                next_st.latched = 1'b0;
            end else if (cfg.latch && st.dly && !st.armed) begin
                next_st.latched = 1'b1;
            end
            next_st.out = (next_st.dly | next_st.latched) & ~next_st.armed;
            next_st.fire = next_st.out & ~st.out;
        end
    end

    // State register; stand-by starts armed after every reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st <= '{armed: 1'b1, default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign alarm = st.out;
    assign fire = st.fire;
endmodule
`default_nettype wire

/* hw/llc_top.sv */
// Purpose: Latching limit supervisor with three alarms and contact I/O.
// Assumes: All inputs synchronous to core_clk; APB slave, zero wait while ce is high.
// Notes: Relay output is high while the limit relay coil is energized.
//
// Contract
// R1 - One setpoint, high or low latching limit
// R2 - Limit crossed: exceeded on, trip on, relay off
// R3 - Back to normal: exceeded off, trip stays
// R4 - Trip clears only on operator confirmation
// R5 - Confirm from key or contact, selectable
// R6 - Confirm ignored while limit still exceeded
// R7 - Relay de-energized while trip is set
// R8 - Three independent alarms, each own output
// R9 - Stand-by, latch, hysteresis, on/off delays
// R10 - Alarm kinds: PV, deviation, rate, diagnosis, fail
// R11 - First input confirms; others assignable functions
// R12 - Low mode below, high mode above setpoint
// R13 - Confirm acts on rising edge only
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module llc_top #(
    parameter int unsigned TICK_CYCLES = llc_pkg::TICK_CYCLES
) (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Register bus
    input wire llc_pkg::llc_apb_req_t apb_req,
    output llc_pkg::llc_apb_rsp_t apb_rsp,
    // Measurement and health
    input wire logic signed [15:0] process_value,
    input wire logic diag_err,
    input wire logic input_fail,
    // Operator and contacts
    input wire logic confirm_key,
    input wire logic first_contact_input,
    input wire logic [2:0] contact_in,
    // Lamps and relays
    output logic exceeded_lamp,
    output logic trip_lamp,
    output logic relay_energize,
    output logic [2:0] alarm_out,
    // Display controls and interrupt
    output logic pv_red,
    output logic backlight_on,
    output logic [3:0] msg_show,
    output logic irq
);
    import llc_pkg::*;

    // All state of the controller
    typedef struct packed {
        logic exceeded;
        logic trip;
        logic relay;
        logic conf_prev;
        logic [1:0] ctrl;
        logic signed [15:0] sp;
        logic [5:0] int_sts;
        logic [5:0] int_mask;
        logic [11:0] di_assign;
        llc_alm_cfg_t [2:0] alm;
        logic rel_pulse;
        logic [2:0] di_prev;
        logic [31:0] tick_cnt;
        logic tick;
        logic [15:0] pv_prev;
        logic [15:0] rate;
        logic pv_red;
        logic backlight_on;
        logic [3:0] msg_show;
        logic [31:0] prdata;
        logic irq;
    } llc_st_t;

    localparam llc_st_t ST_RST = '{ctrl: CTRL_RST, sp: SP_RST,
        int_mask: MASK_RST, di_assign: DI_RST, relay: 1'b1,
        backlight_on: 1'b1, default: '0};

    llc_st_t st;
    llc_st_t next_st;
    llc_meas_t meas;
    logic [2:0] alm_fire;      // One-cycle alarm events
    logic exceed_now;          // Limit condition this cycle
    logic conf_lvl;            // Selected confirm source
    logic conf_rise;
    logic [5:0] ev;            // Interrupt events
    logic [2:0] di_rise;
    logic bus_setup;
    logic bus_wr;
    logic rd_hit;
    logic [31:0] rd_data;

    // Address of one alarm register
    function automatic logic [7:0] alm_addr(input logic [1:0] n,
                                            input logic [7:0] ofs);
        return 8'(ALM_BASE + ALM_STRIDE * {6'h00, n} + ofs);
    endfunction

    // True when any contact assigned to fn is high in lvl
    function automatic logic di_hit(input logic [11:0] asg,
                                    input logic [2:0] lvl,
                                    input logic [3:0] fn);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < DI_N; i++) begin
            hit = hit | (lvl[i] && (asg[4*i +: 4] == fn));
        end
        return hit;
    endfunction

    // R1 R12 limit direction by mode
    assign exceed_now = st.ctrl[CTRL_LOW_BIT] ? (process_value < st.sp)
                                              : (process_value > st.sp);
    // R5 confirm source select
    // R11 first contact fixed to confirm
    assign conf_lvl = st.ctrl[CTRL_SRC_BIT] ? first_contact_input
                                            : confirm_key;
    // R13 edge, not level
    assign conf_rise = conf_lvl & ~st.conf_prev;
    assign di_rise = contact_in & ~st.di_prev;

    // Bus phases; a frozen block stalls the bus instead of dropping writes
    assign bus_setup = apb_req.psel & ~apb_req.penable;
    assign bus_wr = ce & apb_req.psel & apb_req.penable & apb_req.pwrite
                    & rd_hit;

    // Read decode; also tells which addresses exist
    always_comb begin
        rd_hit = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (apb_req.paddr)
            CTRL_OFS: rd_data = {30'h0000_0000, st.ctrl};
            SETPOINT_OFS: rd_data = {16'h0000, st.sp};
            STATUS_OFS: begin
                rd_data = {process_value, 10'h000, alarm_out,
                           st.relay, st.trip, st.exceeded};
            end
            INT_STATUS_OFS: rd_data = {26'h000_0000, st.int_sts};
            INT_MASK_OFS: rd_data = {26'h000_0000, st.int_mask};
            DI_ASSIGN_OFS: rd_data = {20'h0_0000, st.di_assign};
            // Command register reads back zero
            ALM_CMD_OFS: rd_data = 32'h0000_0000;
            default: rd_hit = 1'b0;
        endcase
        for (int n = 0; n < ALM_N; n++) begin
            if (apb_req.paddr == alm_addr(2'(n), ALM_CFG_OFS)) begin
                rd_hit = 1'b1;
                rd_data = {26'h000_0000, st.alm[n].latch,
                           st.alm[n].standby, st.alm[n].kind};
            end
            if (apb_req.paddr == alm_addr(2'(n), ALM_LEVEL_OFS)) begin
                rd_hit = 1'b1;
                rd_data = {8'h00, st.alm[n].hyst, st.alm[n].limit};
            end
            if (apb_req.paddr == alm_addr(2'(n), ALM_DELAY_OFS)) begin
                rd_hit = 1'b1;
                rd_data = {st.alm[n].off_dly, st.alm[n].on_dly};
            end
        end
    end

    // Next state: limit latch, contacts, timebase, registers
    always_comb begin
        next_st = st;
        ev = 6'h00;
        if (ce) begin
            // Timebase for alarm delays and rate sampling
            next_st.tick = 1'b0;
            if (st.tick_cnt == 32'(TICK_CYCLES - 1)) begin
                next_st.tick_cnt = 32'h0000_0000;
                next_st.tick = 1'b1;
                next_st.pv_prev = process_value;
                next_st.rate = 16'(process_value - st.pv_prev);
            end else begin
                next_st.tick_cnt = st.tick_cnt + 32'h0000_0001;
            end
            // R2 R3 exceeded follows limit
            next_st.exceeded = exceed_now;
            next_st.conf_prev = conf_lvl;
            // R2 set trip; wins over confirm
            // R4 R6 confirm only when normal
            if (exceed_now) begin
                next_st.trip = 1'b1;
            end else if (conf_rise) begin
                next_st.trip = 1'b0;
            end
            // R7 relay off while tripped
            next_st.relay = ~next_st.trip;
            ev[INT_TRIP] = exceed_now & ~st.trip;
            ev[INT_ACCEPT] = conf_rise & ~exceed_now & st.trip;
            ev[INT_REFUSE] = conf_rise & exceed_now;
            ev[INT_ALM_LSB +: ALM_N] = alm_fire;
            // R11 assignable contact functions
            next_st.di_prev = contact_in;
            next_st.pv_red = di_hit(st.di_assign, contact_in, DI_PV_RED);
            next_st.backlight_on = ~di_hit(st.di_assign, contact_in,
                                           DI_BACKLIGHT);
            next_st.msg_show = {
                di_hit(st.di_assign, contact_in, DI_MSG4),
                di_hit(st.di_assign, contact_in, DI_MSG3),
                di_hit(st.di_assign, contact_in, DI_MSG2),
                di_hit(st.di_assign, contact_in, DI_MSG1)};
            next_st.rel_pulse = di_hit(st.di_assign, di_rise,
                                       DI_LATCH_REL);
            // Read data is caught in the setup cycle
            if (bus_setup) begin
                next_st.prdata = rd_data;
            end
            // Register writes at the access edge
            if (bus_wr) begin
                unique case (apb_req.paddr)
                    CTRL_OFS: next_st.ctrl = apb_req.pwdata[1:0];
                    SETPOINT_OFS: next_st.sp = apb_req.pwdata[15:0];
                    INT_MASK_OFS: next_st.int_mask = apb_req.pwdata[5:0];
                    DI_ASSIGN_OFS: begin
                        next_st.di_assign = apb_req.pwdata[11:0];
                    end
                    ALM_CMD_OFS: begin
                        next_st.rel_pulse = next_st.rel_pulse
                            | apb_req.pwdata[ALM_CMD_REL_BIT];
                    end
                    // Interrupt status clears and alarm registers load below; STATUS read-only
                    default: next_st.ctrl = st.ctrl;
                endcase
                for (int n = 0; n < ALM_N; n++) begin
                    if (apb_req.paddr == alm_addr(2'(n), ALM_CFG_OFS)) begin
                        next_st.alm[n].kind = apb_req.pwdata[3:0];
                        next_st.alm[n].standby = apb_req.pwdata[4];
                        next_st.alm[n].latch = apb_req.pwdata[5];
                    end
                    if (apb_req.paddr == alm_addr(2'(n), ALM_LEVEL_OFS)) begin
                        next_st.alm[n].limit = apb_req.pwdata[15:0];
                        next_st.alm[n].hyst = apb_req.pwdata[23:16];
                    end
                    if (apb_req.paddr == alm_addr(2'(n), ALM_DELAY_OFS)) begin
                        next_st.alm[n].on_dly = apb_req.pwdata[15:0];
                        next_st.alm[n].off_dly = apb_req.pwdata[31:16];
                    end
                end
            end
            // Write-one-to-clear; a same-cycle event wins
            if (bus_wr && apb_req.paddr == INT_STATUS_OFS) begin
                next_st.int_sts = st.int_sts & ~apb_req.pwdata[5:0];
            end
            next_st.int_sts = next_st.int_sts | ev;
            next_st.irq = |(next_st.int_sts & next_st.int_mask);
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    // Live values shared by the alarms
    assign meas = '{pv: process_value, sp: st.sp, rate: st.rate,
                    diag: diag_err, fail: input_fail};

    // R8 three independent alarms
    for (genvar g = 0; g < ALM_N; g++) begin : g_alm
        llc_alarm u_alm (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .ce(ce),
            .tick(st.tick),
            .cfg(st.alm[g]),
            .meas(meas),
            .release_req(st.rel_pulse),
            .alarm(alarm_out[g]),
            .fire(alm_fire[g])
        );
    end

    // Outputs
    assign exceeded_lamp = st.exceeded;
    assign trip_lamp = st.trip;
    assign relay_energize = st.relay;
    assign pv_red = st.pv_red;
    assign backlight_on = st.backlight_on;
    assign msg_show = st.msg_show;
    assign irq = st.irq;
    assign apb_rsp = '{pready: ce, pslverr: apb_req.psel & ~rd_hit,
                       prdata: st.prdata};

    // Checks on the limit latch
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    property p_high_mode;
        ce && !st.ctrl[CTRL_LOW_BIT] && process_value > st.sp
        |=> exceeded_lamp;
    endproperty
    a_high_mode: assert property (p_high_mode) // R1
        else $error("high mode missed the limit");

    property p_trip_set;
        ce && exceed_now |=> trip_lamp && exceeded_lamp && !relay_energize;
    endproperty
    a_trip_set: assert property (p_trip_set) // R2
        else $error("limit crossed without trip");

    property p_back_normal;
        ce && !exceed_now && st.trip && !conf_rise
        |=> !exceeded_lamp && trip_lamp;
    endproperty
    a_back_normal: assert property (p_back_normal) // R3
        else $error("trip lost or exceeded stuck on return");

    property p_trip_hold;
        trip_lamp && !(ce && conf_rise && !exceed_now) |=> trip_lamp;
    endproperty
    a_trip_hold: assert property (p_trip_hold) // R4
        else $error("trip cleared without confirmation");

    property p_key_confirm;
        ce && st.trip && !exceed_now && !st.ctrl[CTRL_SRC_BIT]
        && confirm_key && !st.conf_prev |=> !trip_lamp;
    endproperty
    a_key_confirm: assert property (p_key_confirm) // R5
        else $error("key confirmation not taken");

    property p_refuse;
        ce && conf_rise && exceed_now
        |=> trip_lamp && st.int_sts[INT_REFUSE];
    endproperty
    a_refuse: assert property (p_refuse) // R6
        else $error("confirmation taken while exceeded");

    property p_relay_off;
        trip_lamp |-> !relay_energize;
    endproperty
    a_relay_off: assert property (p_relay_off) // R7
        else $error("relay energized while tripped");

    property p_low_mode;
        ce && st.ctrl[CTRL_LOW_BIT] |=> exceeded_lamp == $past(exceed_now)
        && (exceeded_lamp == ($past(process_value) < $past(st.sp)));
    endproperty
    a_low_mode: assert property (p_low_mode) // R12
        else $error("low mode direction wrong");

    property p_held_confirm;
        ce && st.trip && conf_lvl && st.conf_prev |=> trip_lamp;
    endproperty
    a_held_confirm: assert property (p_held_confirm) // R13
        else $error("held confirm cleared a trip");

    c_trip: cover property (ce && exceed_now && !st.trip);
    c_accept: cover property (ce && conf_rise && st.trip && !exceed_now);
    c_refuse: cover property (ce && conf_rise && exceed_now);
    c_alarm: cover property (|alm_fire);
endmodule
`default_nettype wire

/* verif/llc_operator.sv */
// Purpose: Operator model pressing the confirm key or the first contact.
// Assumes: press and to_contact change just after a rising edge.
// Notes: One register stage models the contact's own settling delay.
`timescale 1ns/1ps
`default_nettype none
module llc_operator (
    // Clock
    input wire logic core_clk,
    // Bench commands
    input wire logic press,
    input wire logic to_contact,
    // Lines into the device
    output logic confirm_key,
    output logic first_contact_input
);
    // Both lines rest open until the bench presses
    initial begin
        confirm_key = 1'b0;
        first_contact_input = 1'b0;
    end
    // source and level
    // Only the chosen source is pressed; a held press stays a level
    always @(posedge core_clk) begin
        confirm_key <= press & ~to_contact;
        first_contact_input <= press & to_contact;
    end
endmodule
`default_nettype wire

/* verif/llc_top_tb.sv */
// Purpose: Self-checking bench for the limit latch controller.
// Assumes: ce held high; alarm tick shortened to 10 cycles.
// Notes: Only the diagnosis input stays idle.
`timescale 1ns/1ps
`default_nettype none
module llc_top_tb;
    import llc_pkg::*;
    // Clock, reset, bus and stimulus
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    llc_apb_req_t req = '0;
    llc_apb_rsp_t rsp;
    logic signed [15:0] pv = 16'sh0000;
    logic press = 1'b0;
    logic to_c = 1'b0;
    logic key, cont, exc, trip, relay, irq, perr;
    logic [2:0] alm;
    logic fl = 1'b0;
    logic [2:0] ci = 3'h0;
    logic red, bl;
    logic [3:0] msg;
    logic [31:0] q;
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    // Free-running 4 ns clock
    always #2 core_clk = ~core_clk;
    llc_top #(.TICK_CYCLES(10)) u_dut (.core_clk(core_clk),
        .sys_rst(sys_rst), .ce(1'b1), .apb_req(req), .apb_rsp(rsp),
        .process_value(pv), .diag_err(1'b0), .input_fail(fl),
        .confirm_key(key), .first_contact_input(cont),
        .contact_in(ci), .exceeded_lamp(exc), .trip_lamp(trip),
        .relay_energize(relay), .alarm_out(alm), .pv_red(red),
        .backlight_on(bl), .msg_show(msg), .irq(irq));
    llc_operator u_op (.core_clk(core_clk), .press(press),
        .to_contact(to_c), .confirm_key(key), .first_contact_input(cont));
    // Verdict and end of run
    task automatic finish_test();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard: a stuck wait counts as a mismatch
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Let n edges pass, then look after their updates land
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // One APB transfer; holds the request until pready at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        req.psel <= 1'b1;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge core_clk);
        req.penable <= 1'b1;
        do @(posedge core_clk); while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        perr = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic set_pv(input logic [15:0] v);
        @(posedge core_clk);
        pv <= v;
        wt(2);
    endtask
    task automatic push(input logic on, input logic src);
        @(posedge core_clk);
        press <= on;
        to_c <= src;
        wt(4);
    endtask
    // High mode, key source: trip, refused confirm, held key, clear
    task automatic t_high();
        apb(1'b1, INT_MASK_OFS, 32'h0000_0001);
        apb(1'b1, SETPOINT_OFS, 32'h0000_0064);
        apb(1'b1, CTRL_OFS, 32'h0000_0000);
        set_pv(16'h00C8);
        chk({exc, trip, relay, irq}, 4'hD);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(q, 32'h00C8_0003);
        push(1'b1, 1'b0);
        chk({exc, trip, relay}, 3'h6);
        set_pv(16'h0064);
        chk({exc, trip, relay}, 3'h2);
        wt(3);
        chk(trip, 1'b1);
        push(1'b0, 1'b0);
        push(1'b1, 1'b0);
        chk({trip, relay}, 2'h1);
        push(1'b0, 1'b0);
        apb(1'b1, INT_STATUS_OFS, 32'h0000_003F);
        wt(2);
        chk(irq, 1'b0);
    endtask
    // Low mode, contact source: key ignored, contact clears
    task automatic t_low();
        apb(1'b1, CTRL_OFS, 32'h0000_0003);
        set_pv(16'h0032);
        chk({exc, trip, relay}, 3'h6);
        set_pv(16'h0096);
        push(1'b1, 1'b0);
        chk(trip, 1'b1);
        push(1'b0, 1'b0);
        push(1'b1, 1'b1);
        chk({exc, trip, relay}, 3'h1);
        push(1'b0, 1'b1);
    endtask
    // Unmapped read is refused with zero data
    task automatic t_bus();
        apb(1'b0, 8'hFC, 32'h0);
        chk(perr, 1'b1);
        chk(q, 32'h0000_0000);
    endtask
    // Alarm one as process-value high at 300
    task automatic t_alarm();
        apb(1'b1, ALM_BASE + ALM_LEVEL_OFS, 32'h0000_012C);
        apb(1'b1, ALM_BASE + ALM_CFG_OFS, 32'h0000_0001);
        wt(30);
        chk(alm, 3'h0);
        set_pv(16'h0190);
        wt(40);
        chk(alm, 3'h1);
        // Latched alarm survives the return until released
        apb(1'b1, ALM_BASE + ALM_CFG_OFS, 32'h0000_0021);
        set_pv(16'h0096);
        wt(4);
        chk(alm, 3'h1);
        apb(1'b1, ALM_CMD_OFS, 32'h0000_0001);
        wt(2);
        chk(alm, 3'h0);
        // Alarm two follows the input failure line
        apb(1'b1, ALM_BASE + ALM_STRIDE, 32'h0000_0009);
        @(posedge core_clk);
        fl <= 1'b1;
        wt(3);
        chk(alm, 3'h2);
    endtask
    // Assignable contacts: red, backlight off, message four
    task automatic t_di();
        apb(1'b1, DI_ASSIGN_OFS, 32'h0000_0732);
        @(posedge core_clk);
        ci <= 3'h7;
        wt(2);
        chk({red, bl, msg}, 6'h28);
        @(posedge core_clk);
        ci <= 3'h0;
        wt(2);
        chk({red, bl, msg}, 6'h10);
    endtask
    // Reset for five cycles, then run the scenarios
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        wt(1);
        chk({exc, trip, relay, irq}, 4'h2);
        t_high();
        t_low();
        t_bus();
        t_alarm();
        t_di();
        finish_test();
    end
endmodule
`default_nettype wire
